/* File: gtm_timer.sv */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
// Overview of operation
// - Masked status shows half B timeout 8, RTC 3, capture A 2/1, timeout 0.
// - Clear register write of one clears raw and masked bit, zeros untouched.
// - In 32-bit config upper half A load writes and reads half B load.
// - In 16-bit config upper half A load reads zero, writes ignored.
// - Lower half A load write also loads the half A counter.
// - Load and match reset lower ones; upper ones in 32-bit, zero in 16-bit.
// - In 32-bit config half B load reads live half B count, ignores writes.
// - 32-bit RTC compares both match halves to both counter halves.
// - PWM duty set by match value against load-driven count period.
// - Edge count completes after load minus match edges.
// - In 16-bit config upper half A match reads zero, writes ignored.
// - Each half has prescale and prescale match, widening the PWM compare to 24 bits.
// - Count readback is live except in edge count, showing last edge stamp.
// - Masked status bit set only when event seen and mask bit one.
// - Mask bit one enables a source, zero disables it.
module gtm_timer (
  input  wire logic        i_clk,     // 40 MHz system clock
  input  wire logic        i_nrst,    // Synchronous reset, active low
  input  wire logic [11:0] i_awaddr,  // Write address
  input  wire logic        i_awvalid, // Write address valid
  output logic             o_awready, // Write address ready
  input  wire logic [31:0] i_wdata,   // Write data
  input  wire logic [3:0]  i_wstrb,   // Write byte strobes
  input  wire logic        i_wvalid,  // Write data valid
  output logic             o_wready,  // Write data ready
  output logic [1:0]       o_bresp,   // Write response
  output logic             o_bvalid,  // Write response valid
  input  wire logic        i_bready,  // Write response ready
  input  wire logic [11:0] i_araddr,  // Read address
  input  wire logic        i_arvalid, // Read address valid
  output logic             o_arready, // Read address ready
  output logic [31:0]      o_rdata,   // Read data
  output logic [1:0]       o_rresp,   // Read response
  output logic             o_rvalid,  // Read data valid
  input  wire logic        i_rready,  // Read data ready
  input  wire logic [1:0]  i_ccp,     // Edge inputs, bit 0 half A
  output logic             o_pwm_a,   // Half A PWM output
  output logic             o_pwm_b,   // Half B PWM output
  output logic             o_irq      // Level interrupt
);
  import gtm_pkg::*;

  gtm_state_t s_q;
  gtm_state_t s_d;

  function automatic logic [31:0] gtm_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : gtm_merge

  always_comb
  begin
    logic        is32;
    logic [31:0] c32;
    logic [31:0] t;
    logic [31:0] rd;
    logic        rerr;
    logic [10:0] ev;
    logic [10:0] clr;
    logic        en;
    logic        inv;
    logic        edg;
    logic        tick;
    logic [1:0]  esel;
    logic [15:0] dec;
    s_d  = s_q;
    c32  = 32'h0000_0000;
    t    = 32'h0000_0000;
    rd   = 32'h0000_0000;
    rerr = 1'b0;
    ev   = 11'h000;
    clr  = 11'h000;
    en   = 1'b0;
    inv  = 1'b0;
    edg  = 1'b0;
    tick = 1'b0;
    esel = 2'h0;
    dec  = 16'h0000;
    is32 = (s_q.cfg[2] == 1'b0);
    // Pins cross two flops before edge detection
    s_d.sync1 = i_ccp;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.tbase = s_q.tbase + 16'h0001;

    // Chained 32-bit operation, prescaler unused here
    if (is32 && s_q.ctl[GTM_CTL_EN])
    begin
      c32 = {s_q.cnt[1], s_q.cnt[0]};
      if (s_q.cfg == GTM_CFG_RTC)
      begin
        if (s_q.ctl[GTM_CTL_RTC_EN])
        begin
          c32 = c32 + 32'h0000_0001;
          if (c32 == {s_q.match[1], s_q.match[0]})
          begin
            ev[GTM_RTC_BIT] = 1'b1;
          end
        end
      end
      else if (c32 == 32'h0000_0000)
      begin
        ev[GTM_TO_BIT] = 1'b1;
        c32 = {s_q.load[1], s_q.load[0]};
        if (s_q.mode[0] == GTM_MODE_ONESHOT)
        begin
          s_d.ctl[GTM_CTL_EN] = 1'b0;
        end
      end
      else
      begin
        c32 = c32 - 32'h0000_0001;
      end
      s_d.cnt[1] = c32[31:16];
      s_d.cnt[0] = c32[15:0];
    end

    for (int h = 0; h < 2; h++)
    begin
      en   = s_q.ctl[h*GTM_HALF_STRIDE + GTM_CTL_EN];
      inv  = s_q.ctl[h*GTM_HALF_STRIDE + GTM_CTL_INV];
      esel = s_q.ctl[h*GTM_HALF_STRIDE + GTM_CTL_EDGE_LO +: 2];
      case (esel)
        GTM_EDGE_POS:  edg = s_q.sync2[h] & ~s_q.prev[h];
        GTM_EDGE_NEG:  edg = ~s_q.sync2[h] & s_q.prev[h];
        GTM_EDGE_BOTH: edg = s_q.sync2[h] ^ s_q.prev[h];
        default:       edg = 1'b0;
      endcase
      tick = (s_q.ps[h] == 8'h00);
      dec  = s_q.cnt[h] - 16'h0001;
      s_d.pwm[h] = inv;
      if (!is32 && en)
      begin
        case (s_q.mode[h])
          GTM_MODE_EDGE:
          begin
            if (edg)
            begin
              s_d.stamp[h] = s_q.tbase;
              ev[h*GTM_HALF_STRIDE + GTM_EVENT_BIT] = 1'b1;
              if (dec == s_q.match[h])
              begin
                ev[h*GTM_HALF_STRIDE + GTM_MATCH_BIT] = 1'b1;
                s_d.cnt[h] = s_q.load[h];
                s_d.ctl[h*GTM_HALF_STRIDE + GTM_CTL_EN] = 1'b0;
              end
              else
              begin
                s_d.cnt[h] = dec;
              end
            end
          end
          GTM_MODE_PWM:
          begin
            s_d.ps[h] = tick ? s_q.ps_reg[h] : s_q.ps[h] - 8'h01;
            if (tick)
            begin
              s_d.cnt[h] = (s_q.cnt[h] == 16'h0000) ? s_q.load[h] : dec;
            end
            s_d.pwm[h] = ({s_q.cnt[h], s_q.ps[h]} > {s_q.match[h], s_q.pm_reg[h]}) ^ inv;
          end
          default:
          begin
            s_d.ps[h] = tick ? s_q.ps_reg[h] : s_q.ps[h] - 8'h01;
            if (tick)
            begin
              if (s_q.cnt[h] == 16'h0000)
              begin
                ev[h*GTM_HALF_STRIDE + GTM_TO_BIT] = 1'b1;
                s_d.cnt[h] = s_q.load[h];
                if (s_q.mode[h] == GTM_MODE_ONESHOT)
                begin
                  s_d.ctl[h*GTM_HALF_STRIDE + GTM_CTL_EN] = 1'b0;
                end
              end
              else
              begin
                s_d.cnt[h] = dec;
              end
            end
          end
        endcase
      end
    end

    if (s_q.bvalid && i_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && i_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (i_awvalid && s_q.aw_rdy)
    begin
      s_d.aw_ok  = 1'b1;
      s_d.awaddr = i_awaddr;
    end
    if (i_wvalid && s_q.w_rdy)
    begin
      s_d.w_ok  = 1'b1;
      s_d.wdata = i_wdata;
      s_d.wstrb = i_wstrb;
    end

    // Address and data may arrive in either order
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid)
    begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = GTM_RESP_OKAY;
      case (s_q.awaddr)
        GTM_CFG_OFS:
        begin
          t = gtm_merge({29'h0, s_q.cfg}, s_q.wdata, s_q.wstrb);
          s_d.cfg = t[2:0];
        end
        GTM_MODE_A_OFS:
        begin
          t = gtm_merge({30'h0, s_q.mode[0]}, s_q.wdata, s_q.wstrb);
          s_d.mode[0] = t[1:0];
        end
        GTM_MODE_B_OFS:
        begin
          t = gtm_merge({30'h0, s_q.mode[1]}, s_q.wdata, s_q.wstrb);
          s_d.mode[1] = t[1:0];
        end
        GTM_CTL_OFS:
        begin
          t = gtm_merge({16'h0, s_q.ctl}, s_q.wdata, s_q.wstrb);
          s_d.ctl = t[15:0] & GTM_CTL_MASK;
        end
        GTM_IMR_OFS:
        begin
          t = gtm_merge({21'h0, s_q.imr}, s_q.wdata, s_q.wstrb);
          s_d.imr = t[10:0] & GTM_IRQ_MASK;
        end
        GTM_ICR_OFS:
        begin
          t = gtm_merge(32'h0000_0000, s_q.wdata, s_q.wstrb);
          clr = t[10:0] & GTM_IRQ_MASK;
        end
        GTM_LOAD_A_OFS:
        begin
          t = gtm_merge({s_q.load[1], s_q.load[0]}, s_q.wdata, s_q.wstrb);
          s_d.load[0] = t[15:0];
          s_d.cnt[0]  = t[15:0];
          if (is32)
          begin
            s_d.load[1] = t[31:16];
            s_d.cnt[1]  = t[31:16];
          end
        end
        GTM_LOAD_B_OFS:
        begin
          if (!is32)
          begin
            t = gtm_merge({16'h0, s_q.load[1]}, s_q.wdata, s_q.wstrb);
            s_d.load[1] = t[15:0];
            s_d.cnt[1]  = t[15:0];
          end
        end
        GTM_MATCH_A_OFS:
        begin
          t = gtm_merge({s_q.match[1], s_q.match[0]}, s_q.wdata, s_q.wstrb);
          s_d.match[0] = t[15:0];
          if (is32)
          begin
            s_d.match[1] = t[31:16];
          end
        end
        GTM_MATCH_B_OFS:
        begin
          t = gtm_merge({16'h0, s_q.match[1]}, s_q.wdata, s_q.wstrb);
          s_d.match[1] = t[15:0];
        end
        GTM_PS_A_OFS, GTM_PS_B_OFS:
        begin
          t = gtm_merge(32'h0000_0000, s_q.wdata, s_q.wstrb);
          s_d.ps_reg[s_q.awaddr[2]] = t[7:0];
        end
        GTM_PM_A_OFS, GTM_PM_B_OFS:
        begin
          t = gtm_merge(32'h0000_0000, s_q.wdata, s_q.wstrb);
          s_d.pm_reg[s_q.awaddr[2]] = t[7:0];
        end
        // Read-only registers accept and drop writes
        GTM_RIS_OFS, GTM_MIS_OFS, GTM_CNT_A_OFS, GTM_CNT_B_OFS: s_d.bresp = GTM_RESP_OKAY;
        default: s_d.bresp = GTM_RESP_SLVERR;
      endcase
    end

    if (i_arvalid && s_q.ar_rdy)
    begin
      case (i_araddr)
        GTM_CFG_OFS:     rd = {29'h0, s_q.cfg};
        GTM_MODE_A_OFS:  rd = {30'h0, s_q.mode[0]};
        GTM_MODE_B_OFS:  rd = {30'h0, s_q.mode[1]};
        GTM_CTL_OFS:     rd = {16'h0, s_q.ctl};
        GTM_IMR_OFS:     rd = {21'h0, s_q.imr};
        GTM_RIS_OFS:     rd = {21'h0, s_q.ris};
        GTM_MIS_OFS:     rd = {21'h0, s_q.ris & s_q.imr};
        GTM_ICR_OFS:     rd = 32'h0000_0000;
        GTM_LOAD_A_OFS:  rd = {is32 ? s_q.load[1] : 16'h0000, s_q.load[0]};
        GTM_LOAD_B_OFS:  rd = {16'h0, is32 ? s_q.cnt[1] : s_q.load[1]};
        GTM_MATCH_A_OFS: rd = {is32 ? s_q.match[1] : 16'h0000, s_q.match[0]};
        GTM_MATCH_B_OFS: rd = {16'h0, s_q.match[1]};
        GTM_PS_A_OFS:    rd = {24'h0, s_q.ps_reg[0]};
        GTM_PS_B_OFS:    rd = {24'h0, s_q.ps_reg[1]};
        GTM_PM_A_OFS:    rd = {24'h0, s_q.pm_reg[0]};
        GTM_PM_B_OFS:    rd = {24'h0, s_q.pm_reg[1]};
        GTM_CNT_A_OFS:
          rd = is32 ? {s_q.cnt[1], s_q.cnt[0]}
                    : {16'h0, (s_q.mode[0] == GTM_MODE_EDGE) ? s_q.stamp[0] : s_q.cnt[0]};
        GTM_CNT_B_OFS:
          rd = {16'h0, (s_q.mode[1] == GTM_MODE_EDGE) ? s_q.stamp[1] : s_q.cnt[1]};
        default:         rerr = 1'b1;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
      s_d.rresp  = rerr ? GTM_RESP_SLVERR : GTM_RESP_OKAY;
    end

    s_d.ris = ((s_q.ris & ~clr) | ev) & GTM_IRQ_MASK;
    s_d.irq = |(s_d.ris & s_d.imr);
    // Ready flops hold off until the previous answer is taken
    s_d.aw_rdy = !s_d.aw_ok && !s_d.bvalid;
    s_d.w_rdy  = !s_d.w_ok && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      // ones at reset, config resets chained
      s_q.load  <= {GTM_HALF_ONES, GTM_HALF_ONES};
      s_q.match <= {GTM_HALF_ONES, GTM_HALF_ONES};
      s_q.cnt   <= {GTM_HALF_ONES, GTM_HALF_ONES};
      s_q.cfg   <= GTM_CFG_32;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_awready = s_q.aw_rdy;
  assign o_wready  = s_q.w_rdy;
  assign o_bresp   = s_q.bresp;
  assign o_bvalid  = s_q.bvalid;
  assign o_arready = s_q.ar_rdy;
  assign o_rdata   = s_q.rdata;
  assign o_rresp   = s_q.rresp;
  assign o_rvalid  = s_q.rvalid;
  assign o_pwm_a   = s_q.pwm[0];
  assign o_pwm_b   = s_q.pwm[1];
  assign o_irq     = s_q.irq;
endmodule : gtm_timer

/* File: gtm_pkg.sv */
package gtm_pkg;
  localparam logic [11:0] GTM_CFG_OFS     = 12'h000;
  localparam logic [11:0] GTM_MODE_A_OFS  = 12'h004;
  localparam logic [11:0] GTM_MODE_B_OFS  = 12'h008;
  localparam logic [11:0] GTM_CTL_OFS     = 12'h00C;
  localparam logic [11:0] GTM_IMR_OFS     = 12'h018;
  localparam logic [11:0] GTM_RIS_OFS     = 12'h01C;
  localparam logic [11:0] GTM_MIS_OFS     = 12'h020;
  localparam logic [11:0] GTM_ICR_OFS     = 12'h024;
  localparam logic [11:0] GTM_LOAD_A_OFS  = 12'h028;
  localparam logic [11:0] GTM_LOAD_B_OFS  = 12'h02C;
  localparam logic [11:0] GTM_MATCH_A_OFS = 12'h030;
  localparam logic [11:0] GTM_MATCH_B_OFS = 12'h034;
  localparam logic [11:0] GTM_PS_A_OFS    = 12'h038;
  localparam logic [11:0] GTM_PS_B_OFS    = 12'h03C;
  localparam logic [11:0] GTM_PM_A_OFS    = 12'h040;
  localparam logic [11:0] GTM_PM_B_OFS    = 12'h044;
  localparam logic [11:0] GTM_CNT_A_OFS   = 12'h048;
  localparam logic [11:0] GTM_CNT_B_OFS   = 12'h04C;
  // Status bit layout, half B sits one stride above half A
  localparam int GTM_TO_BIT      = 0;
  localparam int GTM_MATCH_BIT   = 1;
  localparam int GTM_EVENT_BIT   = 2;
  localparam int GTM_RTC_BIT     = 3;
  localparam int GTM_HALF_STRIDE = 8;
  localparam logic [10:0] GTM_IRQ_MASK = 11'h70F;
  // Control bit layout per half
  localparam int GTM_CTL_EN      = 0;
  localparam int GTM_CTL_EDGE_LO = 2;
  localparam int GTM_CTL_RTC_EN  = 4;
  localparam int GTM_CTL_INV     = 6;
  localparam logic [15:0] GTM_CTL_MASK = 16'h6F7F;
  localparam logic [2:0] GTM_CFG_32  = 3'h0;
  localparam logic [2:0] GTM_CFG_RTC = 3'h1;
  localparam logic [2:0] GTM_CFG_16  = 3'h4;
  localparam logic [1:0] GTM_MODE_PERIODIC = 2'h0;
  localparam logic [1:0] GTM_MODE_ONESHOT  = 2'h1;
  localparam logic [1:0] GTM_MODE_EDGE     = 2'h2;
  localparam logic [1:0] GTM_MODE_PWM      = 2'h3;
  localparam logic [1:0] GTM_EDGE_POS  = 2'h0;
  localparam logic [1:0] GTM_EDGE_NEG  = 2'h1;
  localparam logic [1:0] GTM_EDGE_BOTH = 2'h3;
  localparam logic [15:0] GTM_HALF_ONES = 16'hFFFF;
  localparam logic [1:0] GTM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] GTM_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic             aw_rdy;
    logic             w_rdy;
    logic             ar_rdy;
    logic             aw_ok;
    logic [11:0]      awaddr;
    logic             w_ok;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [2:0]       cfg;
    logic [1:0][1:0]  mode;
    logic [15:0]      ctl;
    logic [10:0]      imr;
    logic [10:0]      ris;
    logic [1:0][15:0] load;
    logic [1:0][15:0] match;
    logic [1:0][7:0]  ps_reg;
    logic [1:0][7:0]  pm_reg;
    logic [1:0][15:0] cnt;
    logic [1:0][7:0]  ps;
    logic [1:0][15:0] stamp;
    logic [15:0]      tbase;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       prev;
    logic [1:0]       pwm;
    logic             irq;
  } gtm_state_t;
endpackage : gtm_pkg

/* File: gtm_timer_sva.sv */
`timescale 1ns/10ps
module gtm_timer_sva
  import gtm_pkg::*;
(
  input wire logic        i_clk,     // System clock
  input wire logic        i_nrst,    // Synchronous reset, active low
  input wire logic [11:0] i_awaddr,  // Write address
  input wire logic        i_awvalid, // Write address valid
  input wire logic        o_awready, // Write address ready
  input wire logic [31:0] i_wdata,   // Write data
  input wire logic [3:0]  i_wstrb,   // Write strobes
  input wire logic        i_wvalid,  // Write data valid
  input wire logic        o_wready,  // Write data ready
  input wire logic        o_bvalid,  // Write response valid
  input wire logic [11:0] i_araddr,  // Read address
  input wire logic        i_arvalid, // Read address valid
  input wire logic        o_arready, // Read address ready
  input wire logic [31:0] o_rdata,   // Read data
  input wire logic [1:0]  o_rresp,   // Read response
  input wire logic        o_rvalid,  // Read data valid
  input wire logic        i_rready,  // Read data ready
  input wire logic        o_irq      // Level interrupt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire w_go  = i_awvalid && o_awready && i_wvalid && o_wready;
  wire rd_go = i_arvalid && o_arready;

  property p_rst_quiet;
    $rose(i_nrst) |-> !o_irq && !o_bvalid && !o_rvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  property p_b_ans;
    w_go |-> ##[1:2] o_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write response missing");
  property p_r_ans;
    rd_go |=> o_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read response missing");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_block;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  property p_unmapped;
    rd_go && i_araddr >= 12'h050 |=> o_rresp == GTM_RESP_SLVERR && o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_clear_all;
    w_go && i_awaddr == GTM_ICR_OFS && i_wdata[10:0] == 11'h70F && i_wstrb[1:0] == 2'h3
      |-> ##[1:2] !o_irq;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("interrupt kept after clear");
  property p_irq_hold;
    o_irq && !i_awvalid && !$past(i_awvalid) && !$past(i_awvalid, 2) |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt fell without write");

  c_irq_rise: cover property ($rose(o_irq));
  c_irq_fall: cover property ($fell(o_irq));
  c_rd_wait: cover property (o_rvalid && !i_rready);
endmodule : gtm_timer_sva

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
  import gtm_pkg::*;
  logic        i_clk, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [3:0]  i_wstrb;
  logic [1:0]  i_ccp, o_bresp, o_rresp, r, br;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pwm_a, o_pwm_b, o_irq;
  int          errors = 0;
  int          checks = 0;
  int          hi;
  logic [11:0] pofs [4] = '{GTM_PS_A_OFS, GTM_PS_B_OFS, GTM_PM_A_OFS, GTM_PM_B_OFS};

  gtm_timer DUT (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_ccp, .o_pwm_a, .o_pwm_b, .o_irq);

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Valids held until their own ready; bready stays high
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    i_awaddr  <= a;
    i_wdata   <= v;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    while (n < 60)
    begin
      @(posedge i_clk);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid)
      begin
        br = o_bresp;
        break;
      end
    end
    if (n >= 60) errors++;
  endtask : wr

  // Ready raised late on purpose so the slave must hold its data
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    while (n < 60)
    begin
      @(posedge i_clk);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) break;
      if (o_rvalid) i_rready <= 1'b1;
    end
    v = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
    if (n >= 60) errors++;
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(v, e);
  endtask : rc

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (o_irq !== v && n < 300)
    begin
      @(posedge i_clk);
      n++;
    end
    chk({31'h0, o_irq}, {31'h0, v});
  endtask : wait_irq

  task automatic pulse;
    i_ccp <= 2'b01;
    repeat (4) @(posedge i_clk);
    i_ccp <= 2'b00;
    repeat (4) @(posedge i_clk);
  endtask : pulse

  initial
  begin
    {i_nrst, i_awvalid, i_wvalid, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_ccp} = '0;
    i_wstrb  = 4'hF;
    i_bready = 1'b1;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    rc(GTM_LOAD_A_OFS, 32'hFFFFFFFF);
    rc(GTM_MATCH_A_OFS, 32'hFFFFFFFF);
    rc(GTM_MIS_OFS, 32'h0);
    wr(GTM_LOAD_A_OFS, 32'h00123456);
    rc(GTM_LOAD_A_OFS, 32'h00123456);
    rc(GTM_CNT_A_OFS, 32'h00123456);
    wr(GTM_LOAD_B_OFS, 32'h0000AAAA);
    rc(GTM_LOAD_A_OFS, 32'h00123456);
    rc(GTM_LOAD_B_OFS, 32'h00000012);
    foreach (pofs[k])
    begin
      wr(pofs[k], 32'h123456AB);
      rc(pofs[k], 32'h000000AB);
      wr(pofs[k], 32'h0);
    end
    rd(12'h100, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, GTM_RESP_SLVERR});
    wr(12'h100, 32'h00000001);
    chk({30'h0, br}, {30'h0, GTM_RESP_SLVERR});
    wr(GTM_CFG_OFS, 32'h4);
    chk({30'h0, br}, {30'h0, GTM_RESP_OKAY});
    wr(GTM_LOAD_A_OFS, 32'hABCD0005);
    rc(GTM_LOAD_A_OFS, 32'h00000005);
    wr(GTM_MATCH_A_OFS, 32'hABCD0002);
    rc(GTM_MATCH_A_OFS, 32'h00000002);
    wr(GTM_MODE_A_OFS, 32'h2);
    wr(GTM_IMR_OFS, 32'h2);
    wr(GTM_CTL_OFS, 32'h1);
    pulse();
    rd(GTM_CNT_A_OFS, d, r);
    // Second rising edge comes 11 cycles after the first
    pulse();
    rc(GTM_CNT_A_OFS, d + 32'h0000000B);
    rc(GTM_RIS_OFS, 32'h4);
    chk({31'h0, o_irq}, 32'h0);
    pulse();
    wait_irq(1'b1);
    rc(GTM_MIS_OFS, 32'h2);
    wr(GTM_ICR_OFS, 32'hFFFFF8F9);
    rc(GTM_MIS_OFS, 32'h2);
    rc(GTM_RIS_OFS, 32'h6);
    wr(GTM_IMR_OFS, 32'h0);
    wait_irq(1'b0);
    rc(GTM_MIS_OFS, 32'h0);
    wr(GTM_IMR_OFS, 32'h2);
    wait_irq(1'b1);
    wr(GTM_ICR_OFS, 32'h2);
    rc(GTM_RIS_OFS, 32'h4);
    wait_irq(1'b0);
    wr(GTM_ICR_OFS, 32'h4);
    rc(GTM_RIS_OFS, 32'h0);
    wr(GTM_CTL_OFS, 32'h0);
    wr(GTM_CFG_OFS, 32'h0);
    wr(GTM_MODE_A_OFS, 32'h1);
    wr(GTM_LOAD_A_OFS, 32'h00000020);
    wr(GTM_IMR_OFS, 32'h1);
    wr(GTM_CTL_OFS, 32'h1);
    wait_irq(1'b1);
    rc(GTM_MIS_OFS, 32'h1);
    wr(GTM_ICR_OFS, 32'h70F);
    wait_irq(1'b0);
    wr(GTM_CFG_OFS, 32'h1);
    wr(GTM_LOAD_A_OFS, 32'h0);
    wr(GTM_MATCH_A_OFS, 32'h00000040);
    wr(GTM_IMR_OFS, 32'h8);
    wr(GTM_CTL_OFS, 32'h11);
    chk({31'h0, o_irq}, 32'h0);
    wait_irq(1'b1);
    rc(GTM_MIS_OFS, 32'h8);
    wr(GTM_ICR_OFS, 32'h70F);
    wait_irq(1'b0);
    wr(GTM_CTL_OFS, 32'h0);
    wr(GTM_CFG_OFS, 32'h4);
    wr(GTM_MODE_A_OFS, 32'h3);
    wr(GTM_LOAD_A_OFS, 32'h00000010);
    wr(GTM_MATCH_A_OFS, 32'h00000008);
    wr(GTM_CTL_OFS, 32'h4001);
    // Period is load plus one, high while count above match
    hi = 0;
    repeat (34)
    begin
      @(posedge i_clk);
      if (o_pwm_a) hi++;
    end
    chk(32'(hi), 32'h00000010);
    chk({31'h0, o_pwm_b}, 32'h00000001);
    print_verdict();
  end

  // Whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    errors++;
    print_verdict();
  end
endmodule : tb

bind gtm_timer gtm_timer_sva u_sva (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready,
  .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bvalid, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq);
